// *** design/bcd_pkg.sv ***
package bcd_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = TICK_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int TW = 10;

	function automatic logic [TW-1:0] ceil_ticks(input int ms);
		return TW'((ms + TICK_MS - 1) / TICK_MS);
	endfunction

	function automatic logic [TW-1:0] floor_ticks(input int ms);
		return TW'(ms / TICK_MS);
	endfunction

	localparam int PRESS_MIN_MS = 100;
	localparam int PRESS_MAX_MS = 5000;
	localparam int POWER_WAIT_MS = 2000;
	localparam int PRESS_GAP_MS = 2000;
	localparam int SEQ_CLOSE_MS = 3500;
	localparam int BLINK_ON_MS = 500;
	localparam int BLINK_OFF_MS = 500;
	localparam int DIGIT_GAP_MS = 1500;
	localparam int MSG_GAP_MS = 2500;
	localparam int FINAL_ON_MS = 5000;

	localparam logic [TW-1:0] PRESS_MIN_T = ceil_ticks(PRESS_MIN_MS);
	localparam logic [TW-1:0] PRESS_MAX_T = floor_ticks(PRESS_MAX_MS);
	localparam logic [TW-1:0] SEQ_CLOSE_T = ceil_ticks(SEQ_CLOSE_MS);
	localparam logic [TW-1:0] BLINK_ON_T = ceil_ticks(BLINK_ON_MS);
	localparam logic [TW-1:0] BLINK_OFF_T = ceil_ticks(BLINK_OFF_MS);
	localparam logic [TW-1:0] DIGIT_GAP_T = ceil_ticks(DIGIT_GAP_MS);
	localparam logic [TW-1:0] MSG_GAP_T = ceil_ticks(MSG_GAP_MS);
	localparam logic [TW-1:0] FINAL_ON_T = ceil_ticks(FINAL_ON_MS);

	localparam logic [3:0] PRESS_ACTIVE = 4'h1;
	localparam logic [3:0] PRESS_INACTIVE = 4'h2;
	localparam logic [3:0] PRESS_CLEAR = 4'h3;
	localparam logic [3:0] PRESS_CONFIG = 4'h4;
	localparam logic [3:0] PRESS_DYNO = 4'h5;
	localparam logic [3:0] PRESS_RECONFIG = 4'h7;
	localparam logic [3:0] DYNO_EXIT_PRESSES = 4'h3;
	localparam int CFG_DIGITS = 6;

	localparam logic [1:0] KIND_GENERAL = 2'h0;
	localparam logic [1:0] KIND_WHEEL = 2'h1;
	localparam logic [1:0] KIND_VOLTAGE = 2'h2;
	localparam logic [1:0] KIND_J1939 = 2'h3;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CONFIG = 8'h08;
	localparam logic [7:0] ADDR_CODES = 8'h0c;
	localparam int CTRL_DYNO_BIT = 0;
	localparam int CTRL_HIST_CLR_BIT = 1;
	localparam int CODES_HIST_POS = 16;
	localparam logic [23:0] CONFIG_RST = 24'h26_6151;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_COUNT = 4'h1,
		ST_SEEK = 4'h2,
		ST_LOAD = 4'h3,
		ST_ON = 4'h4,
		ST_OFF = 4'h5,
		ST_GAP = 4'h6,
		ST_FINAL = 4'h7,
		ST_DYNO = 4'h8
	} bcd_state_type;

	typedef enum logic [1:0] {
		SRC_ACTIVE = 2'h0,
		SRC_HISTORY = 2'h1,
		SRC_CONFIG = 2'h2,
		SRC_EMPTY = 2'h3
	} bcd_src_type;
endpackage

// *** design/bcd_press_if.sv ***
`timescale 1ns/1ps
interface bcd_press_if;
	logic tick;
	logic press_ok;
	logic press_stuck;
	logic discard;
	modport src (output tick, output press_ok, output press_stuck,
		input discard);
	modport dst (input tick, input press_ok, input press_stuck,
		output discard);
endinterface

// *** design/bcd_press_timer.sv ***
`timescale 1ns/1ps
module bcd_press_timer #(
	parameter int TICK_CYCLES = bcd_pkg::TICK_CYCLES
) (
	input  wire logic clk_sys_in,
	input  wire logic sys_rst_in,
	input  wire logic button_in,
	bcd_press_if.src  pif
);
	typedef struct packed {
		logic [20:0]              div;
		logic                     tick;
		logic [bcd_pkg::TW-1:0]   held;
		logic                     btn;
		logic                     ok;
		logic                     stuck;
	} bcd_pt_type;

	bcd_pt_type r;
	bcd_pt_type n;

	always_comb
	begin
		n = r;
		n.ok = 1'b0;
		n.stuck = 1'b0;
		n.tick = 1'b0;
		n.btn = button_in;
		// One shared tick times every interval
		if (r.div == 21'(TICK_CYCLES - 1))
		begin
			n.div = '0;
			n.tick = 1'b1;
		end
		else
			n.div = r.div + 21'h1;
		if (pif.discard || !button_in)
			n.held = '0;
		else if (r.tick && r.held != bcd_pkg::PRESS_MAX_T)
		begin
			n.held = r.held + bcd_pkg::TW'(1);
			// Stuck reported once, at the moment the limit passes
			if (n.held == bcd_pkg::PRESS_MAX_T)
				n.stuck = 1'b1;
		end
		if (r.btn && !button_in && !pif.discard &&
			r.held >= bcd_pkg::PRESS_MIN_T &&
			r.held < bcd_pkg::PRESS_MAX_T)
			n.ok = 1'b1;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			r <= '0;
		else
			r <= n;
	end

	assign pif.tick = r.tick;
	assign pif.press_ok = r.ok;
	assign pif.press_stuck = r.stuck;
endmodule

// *** design/bcd_top.sv ***
// Overview of operation
// - No diagnostics entry or stay while moving
// - Valid press lasts 0.1 to 5 seconds
// - Press over five seconds flags faulty switch
// - 3.5 second silence closes count, starts blinking
// - Blinks half second on, half off
// - Digits separated by 1.5 second dark
// - Messages separated by 2.5 second dark
// - Lamp steady five seconds after messages
// - Output runs to end, ignoring the button
// - Ordinary active codes last the power cycle
// - Voltage and J1939 codes self-clear on recovery
// - Press count selects the diagnostic mode
// - Reconfigure only after held-at-power-on, seven presses
// - Active codes shown as two-digit groups
// - Power cycle clears codes; wheel codes need speed
// - Cleared active codes move to history
// - Dyno mode disables traction, kept, tool-set
// - Three presses leave dyno blink mode (lamp is dark, not blinking, in ST_DYNO)
// - Config digits: supply, sensors, modulators
// - Config digits: layout, traction, retarder
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module bcd_top #(
	parameter int TICK_CYCLES = bcd_pkg::TICK_CYCLES,
	parameter int N           = 8
) (
	input  wire logic        clk_sys_in,
	input  wire logic        sys_rst_in,
	input  wire logic        button_in,
	input  wire logic        ign_on_in,
	input  wire logic        motion_in,
	input  wire logic        voltage_ok_in,
	input  wire logic        j1939_ok_in,
	input  wire logic        wheels_valid_in,
	input  wire logic        fault_set_in,
	input  wire logic [9:0]  fault_code_in,
	input  wire logic [1:0]  fault_kind_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	output logic             lamp_out,
	output logic             traction_disable_out,
	output logic             reconfig_out,
	output logic             switch_fault_out,
	output logic             diag_active_out
);
	localparam int IW = $clog2(N);
	localparam logic [3:0] DYNO_LAST = bcd_pkg::DYNO_EXIT_PRESSES - 4'h1;

	typedef struct packed {
		bcd_pkg::bcd_state_type   st;
		bcd_pkg::bcd_src_type     src;
		logic [bcd_pkg::TW-1:0]   tmr;
		logic [3:0]               presses;
		logic [4:0]               blinks;
		logic [IW:0]              msg;
		logic                     dsel;
		logic                     long_gap;
		logic                     shown;
		logic [N-1:0]             act_v;
		logic [N-1:0]             pend;
		logic [N-1:0][9:0]        act_code;
		logic [N-1:0][1:0]        act_kind;
		logic [N-1:0]             hist_v;
		logic [N-1:0][9:0]        hist_code;
		logic [IW-1:0]            wp;
		logic                     armed;
		logic                     wait_rel;
		logic                     dyno;
		logic [23:0]              cfg;
		logic                     sw_fault;
		logic                     lamp;
		logic                     reconfig;
		logic                     diag;
		logic [31:0]              rdata;
	} bcd_core_type;

	bcd_core_type r;
	bcd_core_type n;
	bcd_press_if  pif ();

	logic         clear_all;
	logic         clr;
	logic         found;
	logic [9:0]   cur_code;
	logic         cur_v;
	logic [4:0]   dig;

	bcd_press_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_press (
		.clk_sys_in  (clk_sys_in),
		.sys_rst_in  (sys_rst_in),
		.button_in   (button_in),
		.pif         (pif)
	);

	assign pif.discard = r.wait_rel;

	function automatic logic tick_done(input logic tick,
		input logic [bcd_pkg::TW-1:0] tmr,
		input logic [bcd_pkg::TW-1:0] lim);
		return tick && tmr == lim - bcd_pkg::TW'(1);
	endfunction

	function automatic logic [4:0] pick_digit(
		input bcd_pkg::bcd_src_type s,
		input logic [9:0] code,
		input logic [23:0] cfg,
		input logic [IW:0] msg,
		input logic dsel);
		logic [4:0] d;
		d = 5'h1;
		if (s == bcd_pkg::SRC_CONFIG)
			d = {1'b0, cfg[4 * (bcd_pkg::CFG_DIGITS - 1 - int'(msg)) +: 4]};
		else if (s != bcd_pkg::SRC_EMPTY)
			d = dsel ? code[4:0] : code[9:5];
		// A zero digit cannot be blinked; it shows as one
		return (d == 5'h0) ? 5'h1 : d;
	endfunction

	always_comb
	begin
		cur_code = (r.src == bcd_pkg::SRC_HISTORY) ?
			r.hist_code[r.msg[IW-1:0]] : r.act_code[r.msg[IW-1:0]];
		cur_v = (r.src == bcd_pkg::SRC_HISTORY) ?
			r.hist_v[r.msg[IW-1:0]] : r.act_v[r.msg[IW-1:0]];
		dig = pick_digit(r.src, cur_code, r.cfg, r.msg, r.dsel);
	end

	always_comb
	begin
		n = r;
		n.reconfig = 1'b0;
		n.rdata = '0;
		clear_all = 1'b0;
		clr = 1'b0;
		found = 1'b0;
		if (pif.tick)
			n.tmr = r.tmr + bcd_pkg::TW'(1);

		unique case (r.st)
		bcd_pkg::ST_IDLE:
		begin
			// Moving vehicle never starts a count
			if (pif.press_ok && !motion_in)
			begin
				n.st = bcd_pkg::ST_COUNT;
				n.presses = 4'h1;
				n.tmr = '0;
			end
		end
		bcd_pkg::ST_COUNT:
		begin
			if (pif.press_ok)
			begin
				n.presses = r.presses + 4'h1;
				n.tmr = '0;
			end
			else if (tick_done(pif.tick, r.tmr,
				bcd_pkg::SEQ_CLOSE_T))
			begin
				n.tmr = '0;
				n.msg = '0;
				n.dsel = 1'b0;
				n.shown = 1'b0;
				n.armed = 1'b0;
				n.st = bcd_pkg::ST_IDLE;
				unique case (r.presses)
				bcd_pkg::PRESS_ACTIVE:
				begin
					n.src = bcd_pkg::SRC_ACTIVE;
					n.st = bcd_pkg::ST_SEEK;
				end
				bcd_pkg::PRESS_INACTIVE:
				begin
					n.src = bcd_pkg::SRC_HISTORY;
					n.st = bcd_pkg::ST_SEEK;
				end
				bcd_pkg::PRESS_CLEAR:
				begin
					clear_all = 1'b1;
					n.st = bcd_pkg::ST_FINAL;
				end
				bcd_pkg::PRESS_CONFIG:
				begin
					n.src = bcd_pkg::SRC_CONFIG;
					n.st = bcd_pkg::ST_LOAD;
				end
				bcd_pkg::PRESS_DYNO:
				begin
					n.dyno = 1'b1;
					n.presses = '0;
					n.st = bcd_pkg::ST_DYNO;
				end
				bcd_pkg::PRESS_RECONFIG:
					n.reconfig = r.armed;
				default:
					n.st = bcd_pkg::ST_IDLE;
				endcase
			end
		end
		bcd_pkg::ST_SEEK:
		begin
			// One slot per cycle keeps the scan small
			if (r.msg == (IW+1)'(N))
			begin
				n.msg = '0;
				if (!r.shown && r.src == bcd_pkg::SRC_ACTIVE)
				begin
					n.src = bcd_pkg::SRC_EMPTY;
					n.shown = 1'b1;
					n.st = bcd_pkg::ST_LOAD;
				end
				else
					n.st = bcd_pkg::ST_FINAL;
			end
			else if (cur_v)
			begin
				n.shown = 1'b1;
				n.dsel = 1'b0;
				n.st = bcd_pkg::ST_LOAD;
			end
			else
				n.msg = r.msg + (IW+1)'(1);
			n.tmr = '0;
		end
		bcd_pkg::ST_LOAD:
		begin
			n.blinks = dig;
			n.tmr = '0;
			n.st = bcd_pkg::ST_ON;
		end
		bcd_pkg::ST_ON:
		begin
			if (tick_done(pif.tick, r.tmr, bcd_pkg::BLINK_ON_T))
			begin
				n.tmr = '0;
				n.blinks = r.blinks - 5'h1;
				n.long_gap = r.src == bcd_pkg::SRC_CONFIG || r.dsel;
				n.st = (r.blinks == 5'h1) ? bcd_pkg::ST_GAP :
					bcd_pkg::ST_OFF;
			end
		end
		bcd_pkg::ST_OFF:
		begin
			if (tick_done(pif.tick, r.tmr, bcd_pkg::BLINK_OFF_T))
			begin
				n.tmr = '0;
				n.st = bcd_pkg::ST_ON;
			end
		end
		bcd_pkg::ST_GAP:
		begin
			if (!r.long_gap &&
				tick_done(pif.tick, r.tmr, bcd_pkg::DIGIT_GAP_T))
			begin
				n.tmr = '0;
				n.dsel = 1'b1;
				n.st = bcd_pkg::ST_LOAD;
			end
			else if (r.long_gap &&
				tick_done(pif.tick, r.tmr, bcd_pkg::MSG_GAP_T))
			begin
				n.tmr = '0;
				n.dsel = 1'b0;
				n.msg = r.msg + (IW+1)'(1);
				unique case (r.src)
				bcd_pkg::SRC_CONFIG:
					n.st = (r.msg == (IW+1)'(bcd_pkg::CFG_DIGITS - 1)) ?
						bcd_pkg::ST_FINAL : bcd_pkg::ST_LOAD;
				bcd_pkg::SRC_EMPTY:
					n.st = bcd_pkg::ST_FINAL;
				default:
					n.st = bcd_pkg::ST_SEEK;
				endcase
			end
		end
		bcd_pkg::ST_FINAL:
		begin
			if (tick_done(pif.tick, r.tmr, bcd_pkg::FINAL_ON_T))
			begin
				n.tmr = '0;
				n.st = bcd_pkg::ST_IDLE;
			end
		end
		bcd_pkg::ST_DYNO:
		begin
			if (pif.press_ok)
			begin
				n.presses = r.presses + 4'h1;
				n.tmr = '0;
				if (r.presses == DYNO_LAST)
					n.st = bcd_pkg::ST_IDLE;
			end
			else if (tick_done(pif.tick, r.tmr, bcd_pkg::SEQ_CLOSE_T))
			begin
				n.tmr = '0;
				n.presses = '0;
			end
		end
		default:
			n.st = bcd_pkg::ST_IDLE;
		endcase

		// Motion aborts any diagnostic activity at once
		if (motion_in && r.st != bcd_pkg::ST_IDLE)
		begin
			n.st = bcd_pkg::ST_IDLE;
			n.tmr = '0;
		end

		if (ign_on_in)
		begin
			n.sw_fault = 1'b0;
			n.armed = button_in;
			n.wait_rel = button_in;
		end
		if (!button_in)
			n.wait_rel = 1'b0;
		if (pif.press_stuck)
			n.sw_fault = 1'b1;

		for (int i = 0; i < N; i++)
		begin
			clr = 1'b0;
			if (r.act_v[i])
			begin
				if (ign_on_in)
				begin
					if (r.act_kind[i] == bcd_pkg::KIND_WHEEL)
						n.pend[i] = 1'b1;
					else
						clr = 1'b1;
				end
				else if (r.pend[i] && wheels_valid_in)
					clr = 1'b1;
				if (r.act_kind[i] == bcd_pkg::KIND_VOLTAGE && voltage_ok_in)
					clr = 1'b1;
				if (r.act_kind[i] == bcd_pkg::KIND_J1939 && j1939_ok_in)
					clr = 1'b1;
				if (clear_all)
					clr = 1'b1;
			end
			// Other kinds only leave through the paths above
			if (clr)
			begin
				n.act_v[i] = 1'b0;
				n.pend[i] = 1'b0;
				n.hist_code[n.wp] = r.act_code[i];
				n.hist_v[n.wp] = 1'b1;
				n.wp = n.wp + IW'(1);
			end
		end

		// A new report wins over a clear in the same cycle
		if (fault_set_in)
		begin
			for (int i = 0; i < N; i++)
			begin
				if (n.act_v[i] && n.act_code[i] == fault_code_in)
					found = 1'b1;
			end
			for (int i = 0; i < N; i++)
			begin
				if (!found && !n.act_v[i])
				begin
					n.act_v[i] = 1'b1;
					n.pend[i] = 1'b0;
					n.act_code[i] = fault_code_in;
					n.act_kind[i] = fault_kind_in;
					found = 1'b1;
				end
			end
		end

		if (reg_wr_in)
		begin
			if (reg_addr_in == bcd_pkg::ADDR_CTRL)
			begin
				n.dyno = reg_wdata_in[bcd_pkg::CTRL_DYNO_BIT];
				if (reg_wdata_in[bcd_pkg::CTRL_HIST_CLR_BIT])
				begin
					n.hist_v = '0;
					n.wp = '0;
				end
			end
			else if (reg_addr_in == bcd_pkg::ADDR_CONFIG)
				n.cfg = reg_wdata_in[23:0];
		end
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
			bcd_pkg::ADDR_CTRL:
				n.rdata = 32'(r.dyno);
			bcd_pkg::ADDR_STATUS:
				n.rdata = 32'({r.armed, r.sw_fault, r.presses, r.st});
			bcd_pkg::ADDR_CONFIG:
				n.rdata = 32'(r.cfg);
			bcd_pkg::ADDR_CODES:
			begin
				n.rdata = 32'(r.act_v);
				n.rdata[bcd_pkg::CODES_HIST_POS +: N] = r.hist_v;
			end
			default:
				n.rdata = '0;
			endcase
		end

		n.lamp = n.st == bcd_pkg::ST_ON || n.st == bcd_pkg::ST_FINAL ||
			(n.st == bcd_pkg::ST_IDLE && |n.act_v);
		n.diag = n.st != bcd_pkg::ST_IDLE;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			r <= '0;
			r.cfg <= bcd_pkg::CONFIG_RST;
		end
		else
			r <= n;
	end

	assign reg_rdata_out = r.rdata;
	assign lamp_out = r.lamp;
	assign traction_disable_out = r.dyno;
	assign reconfig_out = r.reconfig;
	assign switch_fault_out = r.sw_fault;
	assign diag_active_out = r.diag;
endmodule

// *** verif/bcd_checker.sv ***
`timescale 1ns/1ps
module bcd_checker #(
	parameter int TICK_CYCLES = bcd_pkg::TICK_CYCLES
) (
	input wire logic        clk_sys_in,
	input wire logic        sys_rst_in,
	input wire logic        button_in,
	input wire logic        ign_on_in,
	input wire logic        motion_in,
	input wire logic        reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic        lamp_out,
	input wire logic        traction_disable_out,
	input wire logic        reconfig_out,
	input wire logic        switch_fault_out,
	input wire logic        diag_active_out
);
	int   on_len;
	int   off_len;
	int   held_len;
	logic btn_q;
	logic armed_r;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	// Held length survives the release so the fault can be traced to it
	always_ff @(posedge clk_sys_in)
	begin
		on_len <= lamp_out ? on_len + 1 : 0;
		off_len <= lamp_out ? 0 : off_len + 1;
		btn_q <= button_in;
		if (button_in)
			held_len <= btn_q ? held_len + 1 : 1;
		if (sys_rst_in)
			armed_r <= 1'b0;
		else if (ign_on_in)
			armed_r <= button_in;
	end

	sequence moving_s;
		motion_in ##1 motion_in;
	endsequence

	motion_block_a: assert property (moving_s |=> !diag_active_out)
		else $error("diagnostics active while moving");
	// Entry into counting darkens a lit idle lamp; that is no blink end
	blink_on_a: assert property ($fell(lamp_out) && diag_active_out
		&& $past(diag_active_out) |-> on_len >= 49 * TICK_CYCLES)
		else $error("lamp lit too briefly");
	// Short seek gap before a lit start is not a pause
	dark_min_a: assert property ($rose(lamp_out) && diag_active_out
		&& off_len > 3 |-> off_len >= 49 * TICK_CYCLES)
		else $error("dark pause too short");
	stuck_flag_a: assert property ($fell(button_in)
		&& held_len > 502 * TICK_CYCLES |-> ##[1:4] switch_fault_out)
		else $error("long hold not flagged");
	stuck_cause_a: assert property ($rose(switch_fault_out)
		|-> held_len >= 499 * TICK_CYCLES)
		else $error("switch fault without long hold");
	fault_keep_a: assert property (switch_fault_out && !ign_on_in
		|=> switch_fault_out)
		else $error("switch fault lost");
	reconfig_pulse_a: assert property (reconfig_out |=> !reconfig_out)
		else $error("reconfig pulse too long");
	reconfig_arm_a: assert property (reconfig_out |-> armed_r)
		else $error("reconfig without held start");
	dyno_keep_a: assert property (ign_on_in && traction_disable_out
		|=> traction_disable_out)
		else $error("dyno setting lost at power on");
	rdata_idle_a: assert property (!$past(reg_rd_in)
		|-> reg_rdata_out == 32'h0000_0000)
		else $error("read data outside read slot");
endmodule

bind bcd_top bcd_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// *** verif/bcd_tech_model.sv ***
`timescale 1ns/1ps
module bcd_tech_model #(
	parameter int TC = 8
) (
	input  wire logic clk_in,
	input  wire logic ign_in,
	input  wire logic lamp_in,
	output logic      button_out
);
	int   since_ign = 0;
	int   run = 0;
	logic last = 1'b0;
	bit   armed = 1'b0;
	int   runs[$];

	initial button_out = 1'b0;

	// Lamp recorder: lengths of completed lit and dark runs, in cycles
	always @(posedge clk_in)
	begin
		since_ign <= ign_in ? 0 : since_ign + 1;
		if (armed && lamp_in !== last)
		begin
			runs.push_back(run);
			run <= 1;
		end
		else
			run <= run + 1;
		last <= lamp_in;
	end

	task arm();
		@(negedge clk_in);
		runs.delete();
		run = 0;
		last = lamp_in;
		armed = 1'b1;
	endtask

	task disarm();
		@(negedge clk_in);
		armed = 1'b0;
	endtask

	task hold(input bit v);
		@(posedge clk_in);
		button_out <= v;
	endtask

	task presses(input int n, input int w);
		while (since_ign < 200 * TC)
			@(posedge clk_in);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_in);
			button_out <= 1'b1;
			repeat (w * TC) @(posedge clk_in);
			button_out <= 1'b0;
			if (i < n - 1)
				repeat (30 * TC) @(posedge clk_in);
		end
	endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
	localparam int TC = 6;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ign, motion, v_ok, j_ok, w_ok, f_set, r_wr, r_rd;
	logic        button, lamp, trac, recfg, sw_fault, diag;
	logic [9:0]  f_code;
	logic [1:0]  f_kind;
	logic [7:0]  r_addr;
	logic [31:0] r_wdata, r_rdata, rd;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          act[$], exp_q[$], dq[$];
	int          n_hist = 0;
	int          d1, d2, n;

	bcd_top #(.TICK_CYCLES(TC)) dut (.clk_sys_in(clk), .sys_rst_in(rst),
		.button_in(button), .ign_on_in(ign), .motion_in(motion),
		.voltage_ok_in(v_ok), .j1939_ok_in(j_ok), .wheels_valid_in(w_ok),
		.fault_set_in(f_set), .fault_code_in(f_code),
		.fault_kind_in(f_kind), .reg_addr_in(r_addr),
		.reg_wdata_in(r_wdata), .reg_wr_in(r_wr), .reg_rd_in(r_rd),
		.reg_rdata_out(r_rdata), .lamp_out(lamp),
		.traction_disable_out(trac), .reconfig_out(recfg),
		.switch_fault_out(sw_fault), .diag_active_out(diag));
	bcd_tech_model #(.TC(TC)) tech (.clk_in(clk), .ign_in(ign),
		.lamp_in(lamp), .button_out(button));

	always #4 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_mismatch++;
			summarize();
		end
	end

	task summarize();
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task tk(input int t);
		repeat (t * TC) @(posedge clk);
	endtask

	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		r_addr <= a;
		r_wdata <= d;
		r_wr <= 1'b1;
		@(posedge clk);
		r_wr <= 1'b0;
	endtask

	task reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		r_addr <= a;
		r_rd <= 1'b1;
		@(posedge clk);
		r_rd <= 1'b0;
		#1 d = r_rdata;
	endtask

	task pulse_ign();
		@(posedge clk);
		ign <= 1'b1;
		@(posedge clk);
		ign <= 1'b0;
	endtask

	task fault(input int c, input int k);
		@(posedge clk);
		f_set <= 1'b1;
		f_code <= 10'(c);
		f_kind <= 2'(k);
		@(posedge clk);
		f_set <= 1'b0;
		act.push_back(c * 4 + k);
	endtask

	// Cleared active codes move to history; k < 0 clears every kind
	task drop(input int k);
		int keep[$];
		keep = act.find(x) with (k >= 0 && x % 4 != k);
		n_hist += act.size() - keep.size();
		act = keep;
	endtask

	task chk_codes();
		reg_rd(bcd_pkg::ADDR_CODES, rd);
		chk("active codes", act.size(), $countones(rd[7:0]));
		chk("history codes", n_hist, $countones(rd[23:16]));
	endtask

	// Expected lamp runs in ticks, starting with the closing silence
	task build(input int per);
		exp_q = {350};
		foreach (dq[i])
		begin
			for (int b = 0; b < dq[i]; b++)
				exp_q = {exp_q, 50, 50};
			exp_q[exp_q.size() - 1] = (i % per == per - 1) ? 250 : 150;
		end
		exp_q.push_back(500);
	endtask

	// A lit idle lamp hides the end of the final steady run
	task runs_chk(input bit lit);
		int g;
		int o;
		if (lit)
			exp_q = exp_q[0:$-1];
		o = tech.runs.size() - exp_q.size();
		chk("run count", 1, o >= 0);
		foreach (exp_q[i])
		begin
			g = (tech.runs[o + i] + TC / 2) / TC;
			if (g > exp_q[i] + 1 || g + 1 < exp_q[i])
				chk("lamp run", exp_q[i], g);
		end
	endtask

	task wait_idle();
		tk(2);
		while (diag === 1'b1)
			@(posedge clk);
		tk(2);
		tech.disarm();
	endtask

	task rc_count(output int c);
		c = 0;
		repeat (400 * TC)
		begin
			@(posedge clk);
			if (recfg === 1'b1)
				c++;
		end
	endtask

	initial
	begin
		{ign, motion, v_ok, j_ok, w_ok, f_set, r_wr, r_rd} = '0;
		{f_code, f_kind, r_addr, r_wdata} = '0;
		void'($urandom(32'haee4_52e8));
		d1 = $urandom_range(3, 1);
		d2 = $urandom_range(3, 1);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		reg_rd(bcd_pkg::ADDR_CONFIG, rd);
		chk("config reset", 32'h0026_6151, rd);
		reg_rd(8'h10, rd);
		chk("unmapped read", 32'h0000_0000, rd);
		pulse_ign();
		fault(d1 * 32 + d2, 0);
		fault(4 * 32 + 2, 1);
		fault(6 * 32 + 1, 2);
		fault(11 * 32 + 3, 3);
		chk_codes();
		@(posedge clk);
		v_ok <= 1'b1;
		j_ok <= 1'b1;
		tk(2);
		drop(2);
		drop(3);
		chk_codes();
		@(posedge clk);
		motion <= 1'b1;
		tech.presses(1, 20);
		tk(360);
		chk("entry while moving", 0, diag);
		@(posedge clk);
		motion <= 1'b0;
		tech.presses(1, 20);
		tech.arm();
		tk(600);
		tech.presses(1, 20);
		wait_idle();
		dq = {d1, d2, 4, 2};
		build(2);
		runs_chk(1);
		pulse_ign();
		drop(0);
		chk_codes();
		@(posedge clk);
		w_ok <= 1'b1;
		tk(2);
		drop(1);
		chk_codes();
		reg_wr(bcd_pkg::ADDR_CONFIG, 32'h0014_4121);
		tech.presses(4, 20);
		tech.arm();
		wait_idle();
		dq = {1, 4, 4, 1, 2, 1};
		build(1);
		runs_chk(0);
		fault(2 * 32 + 1, 0);
		tech.presses(3, 20);
		wait_idle();
		drop(-1);
		chk_codes();
		tech.presses(2, 20);
		tk(360);
		chk("history readout lamp", 1, lamp);
		@(posedge clk);
		motion <= 1'b1;
		tk(2);
		chk("exit on motion", 0, diag);
		@(posedge clk);
		motion <= 1'b0;
		tech.presses(5, 20);
		tk(360);
		chk("dyno traction off", 1, trac);
		tech.presses(3, 20);
		tk(360);
		chk("dyno exit", 0, diag);
		pulse_ign();
		tk(1);
		chk("dyno kept", 1, trac);
		reg_wr(bcd_pkg::ADDR_CTRL, 32'h0000_0000);
		tk(1);
		chk("dyno by tool", 0, trac);
		tech.hold(1'b1);
		tk(20);
		pulse_ign();
		tk(20);
		tech.hold(1'b0);
		tech.presses(7, 20);
		rc_count(n);
		chk("reconfig held", 1, n);
		pulse_ign();
		tech.presses(7, 20);
		rc_count(n);
		chk("reconfig plain", 0, n);
		tech.presses(1, 5);
		tk(1);
		reg_rd(bcd_pkg::ADDR_STATUS, rd);
		// Count register keeps the last closed sequence until a new one
		chk("short press count", bcd_pkg::PRESS_RECONFIG, rd[7:4]);
		chk("short press state", bcd_pkg::ST_IDLE, rd[3:0]);
		tech.presses(1, 510);
		tk(2);
		chk("switch fault", 1, sw_fault);
		summarize();
	end
endmodule
